// ===== core/out_route_defs.svh
// register offsets, field positions, reset values and gain codes
`ifndef OUT_ROUTE_DEFS_SVH
`define OUT_ROUTE_DEFS_SVH

// register indexes, byte address is four times the index
`define IDX_HP_RIGHT_SRC    6'h0D
`define IDX_LINE_LEFT_SRC   6'h0E
`define IDX_LINE_RIGHT_SRC  6'h0F
`define IDX_HP_LEFT_GAIN    6'h10
`define IDX_HP_RIGHT_GAIN   6'h11

// routing field positions
`define BIT_DAC_NEG         4
`define BIT_DAC_POS         3
`define BIT_ANALOG_IN       2
`define BIT_MIXER_AMP       1
`define BIT_PEER_DRIVER     0

// gain register field positions
`define BIT_MUTE            6
`define GAIN_MSB            5
`define GAIN_LSB            0

// reset values
`define RST_ROUTE           1'b0
`define RST_MUTE            1'b1
`define RST_GAIN            6'h00

// gain codes
`define GAIN_MINUS6         6'h3A
`define GAIN_MAX            6'h1D
`define GAIN_RSV_LO_FIRST   6'h20
`define GAIN_RSV_LO_LAST    6'h39
`define GAIN_RSV_HI_FIRST   6'h1E

`endif

// ===== core/out_route_pkg.sv
// types carried by the routing and gain register bank
package out_route_pkg;

    typedef struct packed {
        logic dac_left_neg;
        logic dac_right_pos;
        logic first_right_analog_input;
        logic right_mixer_amp;
        logic left_headphone_driver;
    } hp_right_route_t;

    typedef struct packed {
        logic dac_right_neg;
        logic dac_left_out;
        logic left_mixer_amp;
        logic right_line_driver;
    } line_left_route_t;

    typedef struct packed {
        logic dac_right_out;
        logic right_mixer_amp;
    } line_right_route_t;

    typedef struct packed {
        logic              mute;
        logic signed [5:0] gain_db;
    } hp_gain_t;

endpackage

// ===== core/output_routing_gain_regs.sv
// output routing and headphone gain register bank on a wishbone slave
// Overview of operation
// - right headphone reg bit 4 links left dac negative terminal to right headphone
// - right headphone reg bit 3 links right dac positive terminal to right headphone
// - right headphone reg bit 2 routes first right analog input there
// - right headphone reg bit 1 routes right mixer amp there
// - right headphone reg bit 0 routes left headphone driver; only on main supply
// - left line reg bit 4 links right dac negative terminal to left line
// - left line reg bit 3 routes left dac output to left line
// - left line reg bit 1 routes left mixer amp to left line
// - left line reg bit 0 routes right line driver; only on main supply
// - right line reg bit 3 routes right dac output to right line
// - right line reg bit 1 routes right mixer amp to right line
// - reserved bits are read-only, read zero; software writes zeros there
// - left gain bit 6 mutes left headphone, resets to muted
// - right gain bit 6 mutes right headphone, resets to muted
// - left six-bit gain is signed dB, -6 to 29, reset 0
// - right six-bit gain uses the same signed dB coding
// - at the -6 dB code of either headphone gain the right headphone mute is not honoured
`timescale 1ns/1ps
`include "out_route_defs.svh"

module output_routing_gain_regs #(
    parameter int AW = 8
) (
    // clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    // wishbone slave
    input  wire logic                              cyc_i,
    input  wire logic                              stb_i,
    input  wire logic                              we_i,
    input  wire logic [AW-1:0]                     adr_i,
    input  wire logic [3:0]                        sel_i,
    input  wire logic [31:0]                       dat_i,
    output logic      [31:0]                       dat_o,
    output logic                                   ack_o,
    // supply state of the output stages, same clock
    input  wire logic                              hp_ldo_supply_i,
    input  wire logic                              line_ldo_supply_i,
    // routing controls
    output out_route_pkg::hp_right_route_t         hp_right_route_o,
    output out_route_pkg::line_left_route_t        line_left_route_o,
    output out_route_pkg::line_right_route_t       line_right_route_o,
    // headphone gain and mute controls
    output out_route_pkg::hp_gain_t                hp_left_gain_o,
    output out_route_pkg::hp_gain_t                hp_right_gain_o,
    output logic                                   hp_left_muted_o,
    output logic                                   hp_right_muted_o,
    // misuse flags
    output logic                                   loop_supply_fault_o,
    output logic                                   gain_code_reserved_o
);

    logic                     ack;
    logic                     req;
    logic                     wr_en;
    logic [5:0]               idx;
    logic [7:0]               rd_byte;
    logic                     hit_hp_right_src;
    logic                     hit_line_left_src;
    logic                     hit_line_right_src;
    logic                     hit_left_gain;
    logic                     hit_right_gain;
    logic                     next_left_mute_eff;
    logic                     next_right_mute_eff;
    logic                     next_loop_fault;
    logic                     next_gain_rsv;
    out_route_pkg::hp_gain_t  next_left_gain;
    out_route_pkg::hp_gain_t  next_right_gain;

    assign req   = cyc_i & stb_i;
    assign idx   = adr_i[7:2];
    assign wr_en = req & ack & we_i & sel_i[0];

    // address decode
    always_comb begin
        hit_hp_right_src   = 1'b0;
        hit_line_left_src  = 1'b0;
        hit_line_right_src = 1'b0;
        hit_left_gain      = 1'b0;
        hit_right_gain     = 1'b0;
        if (idx == `IDX_HP_RIGHT_SRC) begin
            hit_hp_right_src = 1'b1;
        end else if (idx == `IDX_LINE_LEFT_SRC) begin
            hit_line_left_src = 1'b1;
        end else if (idx == `IDX_LINE_RIGHT_SRC) begin
            hit_line_right_src = 1'b1;
        end else if (idx == `IDX_HP_LEFT_GAIN) begin
            hit_left_gain = 1'b1;
        end else if (idx == `IDX_HP_RIGHT_GAIN) begin
            hit_right_gain = 1'b1;
        end
    end

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end
    assign ack_o = ack;

    // read mux, reserved bits and unmapped addresses read zero
    always_comb begin
        rd_byte = 8'h00;
        if (hit_hp_right_src) begin
            rd_byte = {3'h0, hp_right_route_o};
        end else if (hit_line_left_src) begin
            rd_byte = {3'h0, line_left_route_o.dac_right_neg, line_left_route_o.dac_left_out,
                       1'b0, line_left_route_o.left_mixer_amp,
                       line_left_route_o.right_line_driver};
        end else if (hit_line_right_src) begin
            rd_byte = {4'h0, line_right_route_o.dac_right_out, 1'b0,
                       line_right_route_o.right_mixer_amp, 1'b0};
        end else if (hit_left_gain) begin
            rd_byte = {1'b0, hp_left_gain_o};
        end else if (hit_right_gain) begin
            rd_byte = {1'b0, hp_right_gain_o};
        end
    end

    // read data captured with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req & ~ack & ~we_i) begin
            dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // right headphone source select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hp_right_route_o <= '0;
        end else if (wr_en & hit_hp_right_src) begin
            hp_right_route_o.dac_left_neg             <= dat_i[`BIT_DAC_NEG];
            hp_right_route_o.dac_right_pos            <= dat_i[`BIT_DAC_POS];
            hp_right_route_o.first_right_analog_input <= dat_i[`BIT_ANALOG_IN];
            hp_right_route_o.right_mixer_amp          <= dat_i[`BIT_MIXER_AMP];
            hp_right_route_o.left_headphone_driver    <= dat_i[`BIT_PEER_DRIVER];
        end
    end

    // left line source select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_left_route_o <= '0;
        end else if (wr_en & hit_line_left_src) begin
            line_left_route_o.dac_right_neg     <= dat_i[`BIT_DAC_NEG];
            line_left_route_o.dac_left_out      <= dat_i[`BIT_DAC_POS];
            line_left_route_o.left_mixer_amp    <= dat_i[`BIT_MIXER_AMP];
            line_left_route_o.right_line_driver <= dat_i[`BIT_PEER_DRIVER];
        end
    end

    // right line source select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_right_route_o <= '0;
        end else if (wr_en & hit_line_right_src) begin
            line_right_route_o.dac_right_out   <= dat_i[`BIT_DAC_POS];
            line_right_route_o.right_mixer_amp <= dat_i[`BIT_MIXER_AMP];
        end
    end

    // next gain register values
    always_comb begin
        next_left_gain  = hp_left_gain_o;
        next_right_gain = hp_right_gain_o;
        if (wr_en & hit_left_gain) begin
            next_left_gain.mute    = dat_i[`BIT_MUTE];
            next_left_gain.gain_db = signed'(dat_i[`GAIN_MSB:`GAIN_LSB]);
        end
        if (wr_en & hit_right_gain) begin
            next_right_gain.mute    = dat_i[`BIT_MUTE];
            next_right_gain.gain_db = signed'(dat_i[`GAIN_MSB:`GAIN_LSB]);
        end
    end

    // gain and mute registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hp_left_gain_o  <= {`RST_MUTE, `RST_GAIN};
            hp_right_gain_o <= {`RST_MUTE, `RST_GAIN};
        end else begin
            hp_left_gain_o  <= next_left_gain;
            hp_right_gain_o <= next_right_gain;
        end
    end

    // effective mute and misuse flags
    always_comb begin
        next_left_mute_eff  = next_left_gain.mute;
        next_right_mute_eff = next_right_gain.mute
            & (next_right_gain.gain_db != `GAIN_MINUS6)
            & (next_left_gain.gain_db != `GAIN_MINUS6);
        next_loop_fault = (next_route_hp_peer() & hp_ldo_supply_i)
            | (next_route_line_peer() & line_ldo_supply_i);
        next_gain_rsv = gain_rsv(next_left_gain.gain_db)
            | gain_rsv(next_right_gain.gain_db);
    end

    function automatic logic gain_rsv(input logic [5:0] code);
        gain_rsv = ((code >= `GAIN_RSV_LO_FIRST) && (code <= `GAIN_RSV_LO_LAST))
            || (code == `GAIN_RSV_HI_FIRST) || (code == 6'h1F);
    endfunction

    function automatic logic next_route_hp_peer();
        next_route_hp_peer = (wr_en & hit_hp_right_src) ? dat_i[`BIT_PEER_DRIVER]
                                                        : hp_right_route_o.left_headphone_driver;
    endfunction

    function automatic logic next_route_line_peer();
        next_route_line_peer = (wr_en & hit_line_left_src) ? dat_i[`BIT_PEER_DRIVER]
                                                           : line_left_route_o.right_line_driver;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hp_left_muted_o      <= `RST_MUTE;
            hp_right_muted_o     <= `RST_MUTE;
            loop_supply_fault_o  <= 1'b0;
            gain_code_reserved_o <= 1'b0;
        end else begin
            hp_left_muted_o      <= next_left_mute_eff;
            hp_right_muted_o     <= next_right_mute_eff;
            loop_supply_fault_o  <= next_loop_fault;
            gain_code_reserved_o <= next_gain_rsv;
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence hp_right_src_write_s;
        req & ack & we_i & sel_i[0] & hit_hp_right_src;
    endsequence

    sequence line_left_write_s;
        req & ack & we_i & sel_i[0] & hit_line_left_src;
    endsequence

    sequence line_right_write_s;
        req & ack & we_i & sel_i[0] & hit_line_right_src;
    endsequence

    sequence left_gain_write_s;
        req & ack & we_i & sel_i[0] & hit_left_gain;
    endsequence

    sequence right_gain_write_s;
        req & ack & we_i & sel_i[0] & hit_right_gain;
    endsequence

    ack_one_cycle_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    ack_follows_req_a: assert property (req && !ack_o |=> ack_o)
        else $error("no ack after request");

    hp_neg_link_a: assert property (hp_right_src_write_s |=>
        hp_right_route_o.dac_left_neg == $past(dat_i[4]))
        else $error("right headphone dac negative link wrong");

    hp_input_route_a: assert property (hp_right_src_write_s |=>
        hp_right_route_o.first_right_analog_input == $past(dat_i[2]))
        else $error("right analog input route wrong");

    hp_route_all_a: assert property (hp_right_src_write_s |=>
        hp_right_route_o == $past(dat_i[4:0]))
        else $error("right headphone source select wrong");

    line_left_route_a: assert property (line_left_write_s |=>
        line_left_route_o == {$past(dat_i[4]), $past(dat_i[3]), $past(dat_i[1]),
                              $past(dat_i[0])})
        else $error("left line route wrong");

    line_right_route_a: assert property (line_right_write_s |=>
        line_right_route_o == {$past(dat_i[3]), $past(dat_i[1])})
        else $error("right line route wrong");

    route_stable_a: assert property (!(req & ack & we_i) |=>
        $stable(hp_right_route_o) && $stable(line_left_route_o)
        && $stable(line_right_route_o))
        else $error("route changed without write");

    gain_stable_a: assert property (!(req & ack & we_i) |=>
        $stable(hp_left_gain_o) && $stable(hp_right_gain_o))
        else $error("gain changed without write");

    rsv_read_zero_a: assert property (ack_o && !we_i
        && $past(hit_line_right_src) |-> dat_o[7:4] == 4'h0 && dat_o[2] == 1'b0
        && dat_o[0] == 1'b0)
        else $error("reserved bits read nonzero");

    line_left_rsv_a: assert property (ack_o && !we_i
        && $past(hit_line_left_src) |-> dat_o[7:5] == 3'h0 && dat_o[2] == 1'b0)
        else $error("left line reserved bits read nonzero");

    gain_readback_a: assert property (ack_o && !we_i
        && $past(hit_right_gain) |-> dat_o[7:0] == {1'b0, hp_right_gain_o})
        else $error("right gain readback wrong");

    left_gain_wr_a: assert property (left_gain_write_s |=>
        hp_left_gain_o == $past(dat_i[6:0]))
        else $error("left gain register not updated");

    right_gain_wr_a: assert property (right_gain_write_s |=>
        hp_right_gain_o == $past(dat_i[6:0]))
        else $error("right gain register not updated");

    reset_state_a: assert property (disable iff (1'b0)
        rst_i |=> hp_left_gain_o == {`RST_MUTE, `RST_GAIN}
        && hp_right_gain_o == {`RST_MUTE, `RST_GAIN}
        && hp_left_muted_o && hp_right_muted_o && !ack_o
        && hp_right_route_o == '0 && line_left_route_o == '0 && line_right_route_o == '0
        && !loop_supply_fault_o && !gain_code_reserved_o)
        else $error("register state after reset wrong");

    fault_flag_a: assert property (loop_supply_fault_o ==
        ((hp_right_route_o.left_headphone_driver & $past(hp_ldo_supply_i))
        | (line_left_route_o.right_line_driver & $past(line_ldo_supply_i))))
        else $error("loop supply fault flag wrong");

    gain_flag_a: assert property (gain_code_reserved_o ==
        (hp_left_gain_o[5:0] inside {[`GAIN_RSV_LO_FIRST:`GAIN_RSV_LO_LAST],
                                     [`GAIN_RSV_HI_FIRST:6'h1F]}
        || hp_right_gain_o[5:0] inside {[`GAIN_RSV_LO_FIRST:`GAIN_RSV_LO_LAST],
                                        [`GAIN_RSV_HI_FIRST:6'h1F]}))
        else $error("reserved gain code flag wrong");

    right_mute_hold_a: assert property (hp_right_gain_o.mute
        && hp_right_gain_o.gain_db != `GAIN_MINUS6
        && hp_left_gain_o.gain_db != `GAIN_MINUS6 |-> hp_right_muted_o)
        else $error("right headphone not muted");

    right_minus6_a: assert property (hp_right_gain_o.gain_db == `GAIN_MINUS6
        |-> !hp_right_muted_o)
        else $error("right headphone muted at -6 dB");

    left_minus6_a: assert property (hp_left_gain_o.gain_db == `GAIN_MINUS6
        |-> !hp_right_muted_o)
        else $error("right headphone muted at left -6 dB");

    right_unmute_a: assert property (!hp_right_gain_o.mute |-> !hp_right_muted_o)
        else $error("right headphone muted while mute bit clear");

    left_mute_a: assert property (hp_left_muted_o == hp_left_gain_o.mute)
        else $error("left headphone mute mismatch");

endmodule

// ===== tb/testbench.sv
// self-checking bench for the routing and headphone gain register bank
`timescale 1ns/1ps
module testbench;
    logic                                  clk_i = 1'b0;
    logic                                  rst_i = 1'b1;
    logic                                  cyc_i = 1'b0;
    logic                                  stb_i = 1'b0;
    logic                                  we_i = 1'b0;
    logic [7:0]                            adr_i = 8'h00;
    logic [3:0]                            sel_i = 4'h0;
    logic [31:0]                           dat_i = 32'h0;
    logic                                  hp_ldo_supply_i = 1'b0;
    logic                                  line_ldo_supply_i = 1'b0;
    logic [31:0]                           dat_o;
    logic                                  ack_o;
    out_route_pkg::hp_right_route_t        hp_right_route_o;
    out_route_pkg::line_left_route_t       line_left_route_o;
    out_route_pkg::line_right_route_t      line_right_route_o;
    out_route_pkg::hp_gain_t               hp_left_gain_o;
    out_route_pkg::hp_gain_t               hp_right_gain_o;
    logic                                  hp_left_muted_o;
    logic                                  hp_right_muted_o;
    logic                                  loop_supply_fault_o;
    logic                                  gain_code_reserved_o;
    int                                    bad_count = 0;
    int                                    checks_done = 0;
    int                                    cycles = 0;
    logic [7:0]                            m [5] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h40};
    logic [7:0]                            mask [5] = '{8'h1F, 8'h1B, 8'h0A, 8'h7F, 8'h7F};
    logic [5:0]                            codes [8] = '{6'h3A, 6'h00, 6'h1D, 6'h3B,
                                                         6'h20, 6'h39, 6'h1E, 6'h1F};
    logic [31:0]                           q;

    output_routing_gain_regs #(.AW(8)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .hp_ldo_supply_i(hp_ldo_supply_i), .line_ldo_supply_i(line_ldo_supply_i),
        .hp_right_route_o(hp_right_route_o), .line_left_route_o(line_left_route_o),
        .line_right_route_o(line_right_route_o), .hp_left_gain_o(hp_left_gain_o),
        .hp_right_gain_o(hp_right_gain_o), .hp_left_muted_o(hp_left_muted_o),
        .hp_right_muted_o(hp_right_muted_o), .loop_supply_fault_o(loop_supply_fault_o),
        .gain_code_reserved_o(gain_code_reserved_o)
    );

    always #50 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            $display("[ERR] cycle limit expected below 20000 seen %0d", cycles);
            close_out();
        end
    end

    task automatic close_out;
        begin
            $display("checks %0d mismatches %0d", checks_done, bad_count);
            if (bad_count == 0 && checks_done > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask

    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        begin
            checks_done++;
            if (got !== exp) begin
                bad_count++;
                $display("[ERR] %s expected %h seen %h", name, exp, got);
            end
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd);
        begin
            @(posedge clk_i);
            cyc_i <= 1'b1;
            stb_i <= 1'b1;
            we_i  <= w;
            adr_i <= a;
            dat_i <= d;
            sel_i <= s;
            do begin
                @(posedge clk_i);
            end while (ack_o !== 1'b1);
            rd = dat_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            we_i  <= 1'b0;
        end
    endtask

    // bench model update, then write through the bus
    task automatic wr(input int i, input logic [7:0] d, input logic [3:0] s);
        begin
            if (i < 5 && s[0]) m[i] = d & mask[i];
            wb(1'b1, 8'(4 * (13 + i)), {8'($urandom_range(0, 255)), 16'h0, d}, s, q);
        end
    endtask

    task automatic rd_chk(input int i);
        begin
            wb(1'b0, 8'(4 * (13 + i)), 32'h0, 4'hF, q);
            cmp("readback", (i < 5) ? {24'h0, m[i]} : 32'h0, q);
        end
    endtask

    function automatic logic rsv(input logic [5:0] g);
        return (g >= 6'h20 && g <= 6'h39) || g == 6'h1E || g == 6'h1F;
    endfunction

    task automatic chk_outs;
        begin
            @(negedge clk_i);
            cmp("hp_right_route", m[0][4:0], hp_right_route_o);
            cmp("line_left_route", {m[1][4:3], m[1][1:0]}, line_left_route_o);
            cmp("line_right_route", {m[2][3], m[2][1]}, line_right_route_o);
            cmp("hp_left_gain", m[3][6:0], hp_left_gain_o);
            cmp("hp_right_gain", m[4][6:0], hp_right_gain_o);
            cmp("hp_left_muted", m[3][6], hp_left_muted_o);
            cmp("hp_right_muted", m[4][6] && m[3][5:0] != 6'h3A && m[4][5:0] != 6'h3A,
                hp_right_muted_o);
            cmp("loop_fault", (m[0][0] & hp_ldo_supply_i) | (m[1][0] & line_ldo_supply_i),
                loop_supply_fault_o);
            cmp("gain_reserved", rsv(m[3][5:0]) | rsv(m[4][5:0]), gain_code_reserved_o);
        end
    endtask

    initial begin
        void'($urandom(11));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_outs();
        for (int i = 0; i < 6; i++) rd_chk(i);
        for (int i = 0; i < 5; i++) begin
            hp_ldo_supply_i   <= i[0];
            line_ldo_supply_i <= i[0];
            wr(i, 8'hFF, 4'hF);
            chk_outs();
            rd_chk(i);
        end
        for (int k = 0; k < 8; k++) begin
            wr(4, {2'b01, codes[k]}, 4'h1);
            wr(3, {2'b01, codes[7 - k]}, 4'h1);
            chk_outs();
        end
        for (int k = 0; k < 120; k++) begin
            hp_ldo_supply_i   <= 1'($urandom_range(0, 1));
            line_ldo_supply_i <= 1'($urandom_range(0, 1));
            wr($urandom_range(0, 5), 8'($urandom), 4'($urandom));
            chk_outs();
            rd_chk($urandom_range(0, 5));
        end
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        m = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h40};
        chk_outs();
        for (int i = 0; i < 6; i++) rd_chk(i);
        close_out();
    end
endmodule
